/* File: verilog/rsw_ctl.sv */
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`include "rsw_defs.svh"

module rsw_ctl
    import rsw_pkg::*;
#(
    parameter int WDOG_BASE_LOG2 = `RSW_WDOG_BASE_LOG2,
    parameter logic [7:0] CONFIG_RESET = 8'h00
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe_n,
    input wire logic special_mode_pin,
    input wire logic clk_fail,
    output logic core_hold,
    output rsw_fetch_type fetch,
    input wire logic [7:0] fetch_data,
    output logic pc_load,
    output logic [15:0] pc_value
);

    // ==========================================================
    // Functions
    function automatic logic [15:0] vec_base(input rsw_cause_type c, input logic spec);
        logic [15:0] v;
        v = spec ? `RSW_VEC_SPEC_POR : `RSW_VEC_NORM_POR;
        if (c == RSW_CAUSE_CMON) begin
            v = spec ? `RSW_VEC_SPEC_CMON : `RSW_VEC_NORM_CMON;
        end else if (c == RSW_CAUSE_WDOG) begin
            v = spec ? `RSW_VEC_SPEC_WDOG : `RSW_VEC_NORM_WDOG;
        end
        return v;
    endfunction : vec_base

    function automatic logic [21:0] wdog_limit(input logic [1:0] rate);
        return 22'(22'h1 << (WDOG_BASE_LOG2 + 2 * int'(rate)));
    endfunction : wdog_limit

    // ==========================================================
    // Synchronisers
    logic [1:0] pin_sync;
    logic [1:0] mode_sync;
    logic [1:0] fail_sync;
    wire pin_s = pin_sync[1];
    wire mode_s = mode_sync[1];
    wire fail_s = fail_sync[1];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sync <= 2'h3;
            mode_sync <= 2'h0;
            fail_sync <= 2'h0;
        end else begin
            pin_sync <= {pin_sync[0], rst_pin_in};
            mode_sync <= {mode_sync[0], special_mode_pin};
            fail_sync <= {fail_sync[0], clk_fail};
        end
    end

    // ==========================================================
    // Registers and state
    rsw_state_type state;
    rsw_state_type next_state;
    rsw_cause_type cause;
    logic [11:0] cnt;
    logic special;
    logic [7:0] config_reg;
    logic config_locked;
    logic [7:0] option_reg;
    logic option_locked;
    logic [11:0] run_cnt;
    logic test_reset_inhibit;
    logic [21:0] wdog_cnt;
    logic wdog_armed;
    logic [7:0] vec_hi;

    // ==========================================================
    // APB decode
    wire setup = psel && !penable;
    wire wr_en = psel && penable && pready && pwrite && !pslverr;
    wire sel_cfg = paddr == `RSW_OFF_CONFIG;
    wire sel_opt = paddr == `RSW_OFF_OPTION;
    wire sel_svc = paddr == `RSW_OFF_SERVICE;
    wire sel_tst = paddr == `RSW_OFF_TEST;
    wire sel_sta = paddr == `RSW_OFF_STATUS;
    wire mapped = sel_cfg || sel_opt || sel_svc || sel_tst || sel_sta;
    wire [7:0] wbyte = pwdata[7:0];
    wire [31:0] rd_mux = sel_cfg ? {24'h0, config_reg} :
                         sel_opt ? {24'h0, option_reg} :
                         sel_tst ? {31'h0, test_reset_inhibit} :
                         sel_sta ? {24'h0, special, wdog_armed, cause, state} : 32'h0;

    wire cfg_wr = wr_en && sel_cfg && (special || !config_locked);
    wire opt_open = special || (!option_locked && run_cnt < `RSW_OPT_WINDOW);
    wire opt_wr = wr_en && sel_opt;
    wire svc_wr = wr_en && sel_svc;
    wire tst_wr = wr_en && sel_tst && special;

    // ==========================================================
    // Watchdog and clock monitor
    wire running = state == RSW_ST_RUN;
    wire [1:0] rate = option_reg[`RSW_OPT_RATE_LO +: 2];
    wire inhibit = special && test_reset_inhibit;
    wire wdog_en = !config_reg[`RSW_CFG_WDOG_DISABLE] && !inhibit;
    wire svc_clear = svc_wr && wdog_armed && wbyte == `RSW_KEY_CLEAR;
    wire wdog_to = running && wdog_en && wdog_cnt == wdog_limit(rate) - 22'h1;
    wire cmon_to = running && option_reg[`RSW_OPT_CMON_EN] && fail_s;
    wire ext_low = running && !pin_s;
    wire trigger = wdog_to || cmon_to || ext_low;
    wire cnt_done = cnt == 12'h1;

    // ==========================================================
    // Reset sequencer
    always_comb begin
        next_state = state;
        case (state)
            RSW_ST_POR_WAIT: begin
                if (cnt_done) begin
                    next_state = RSW_ST_HOLD;
                end
            end
            RSW_ST_HOLD: begin
                if (pin_s) begin
                    next_state = RSW_ST_DRIVE;
                end
            end
            RSW_ST_DRIVE: begin
                if (cnt_done) begin
                    next_state = RSW_ST_SETTLE;
                end
            end
            RSW_ST_SETTLE: begin
                if (cnt_done) begin
                    next_state = RSW_ST_SAMPLE;
                end
            end
            RSW_ST_SAMPLE: begin
                next_state = pin_s ? RSW_ST_FETCH_HI : RSW_ST_HOLD;
            end
            RSW_ST_FETCH_HI: begin
                next_state = RSW_ST_FETCH_LO;
            end
            RSW_ST_FETCH_LO: begin
                next_state = RSW_ST_LOAD;
            end
            RSW_ST_LOAD: begin
                next_state = RSW_ST_RUN;
            end
            RSW_ST_RUN: begin
                if (trigger) begin
                    next_state = RSW_ST_DRIVE;
                end
            end
            default: begin
                next_state = RSW_ST_POR_WAIT;
            end
        endcase
    end

    wire enter_drive = next_state == RSW_ST_DRIVE && state != RSW_ST_DRIVE;
    wire enter_settle = next_state == RSW_ST_SETTLE && state != RSW_ST_SETTLE;

    // Reset-time power-on path is the only POR source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= RSW_ST_POR_WAIT;
            cnt <= `RSW_POR_WAIT_CYC;
        end else begin
            state <= next_state;
            if (enter_drive) begin
                cnt <= `RSW_DRIVE_CYC;
            end else if (enter_settle) begin
                cnt <= `RSW_SETTLE_CYC + `RSW_SYNC_LAG;
            end else if (cnt != 12'h0) begin
                cnt <= cnt - 12'h1;
            end
        end
    end

    // Cause tracking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause <= RSW_CAUSE_POR;
        end else if (running && trigger) begin
            cause <= wdog_to ? RSW_CAUSE_WDOG : cmon_to ? RSW_CAUSE_CMON : RSW_CAUSE_EXT;
        end else if (state == RSW_ST_SAMPLE && !pin_s) begin
            cause <= RSW_CAUSE_EXT;
        end
    end

    // Mode captured at each reset entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            special <= 1'b0;
        end else if (state == RSW_ST_POR_WAIT || enter_drive) begin
            special <= mode_s;
        end
    end

    // ==========================================================
    // Pin and core outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_pin_out <= 1'b0;
            rst_pin_oe_n <= 1'b1;
            core_hold <= 1'b1;
        end else begin
            rst_pin_out <= 1'b0;
            rst_pin_oe_n <= next_state != RSW_ST_DRIVE;
            core_hold <= next_state != RSW_ST_RUN && next_state != RSW_ST_FETCH_HI
                && next_state != RSW_ST_FETCH_LO && next_state != RSW_ST_LOAD;
        end
    end

    // ==========================================================
    // Vector fetch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch <= '0;
            vec_hi <= 8'h0;
            pc_load <= 1'b0;
            pc_value <= 16'h0;
        end else begin
            fetch.req <= next_state == RSW_ST_FETCH_HI || next_state == RSW_ST_FETCH_LO;
            if (next_state == RSW_ST_FETCH_HI) begin
                fetch.addr <= vec_base(state == RSW_ST_SAMPLE && !pin_s ? RSW_CAUSE_EXT : cause,
                    special);
            end else if (next_state == RSW_ST_FETCH_LO) begin
                fetch.addr <= fetch.addr | 16'h1;
            end
            if (state == RSW_ST_FETCH_LO) begin
                vec_hi <= fetch_data;
            end
            pc_load <= state == RSW_ST_LOAD;
            if (state == RSW_ST_LOAD) begin
                pc_value <= {vec_hi, fetch_data};
            end
        end
    end

    // ==========================================================
    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_reg <= CONFIG_RESET;
            config_locked <= 1'b0;
            option_reg <= `RSW_OPTION_RESET;
            option_locked <= 1'b0;
            run_cnt <= 12'h0;
            test_reset_inhibit <= 1'b0;
        end else if (!running) begin
            config_locked <= 1'b0;
            option_reg <= `RSW_OPTION_RESET;
            option_locked <= 1'b0;
            run_cnt <= 12'h0;
            test_reset_inhibit <= mode_s;
        end else begin
            if (cfg_wr) begin
                config_reg <= wbyte;
                config_locked <= 1'b1;
            end
            if (opt_wr) begin
                option_reg <= opt_open ? wbyte : {option_reg[7:4], wbyte[3], option_reg[2:0]};
                option_locked <= option_locked || opt_open;
            end
            if (run_cnt < `RSW_OPT_WINDOW) begin
                run_cnt <= run_cnt + 12'h1;
            end
            if (tst_wr) begin
                test_reset_inhibit <= wbyte[`RSW_TEST_INHIBIT];
            end
        end
    end

    // Watchdog counter and service key
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_cnt <= 22'h0;
            wdog_armed <= 1'b0;
        end else if (!running || svc_clear || !wdog_en) begin
            wdog_cnt <= 22'h0;
            wdog_armed <= 1'b0;
        end else begin
            wdog_cnt <= wdog_cnt + 22'h1;
            if (svc_wr) begin
                wdog_armed <= wbyte == `RSW_KEY_ARM;
            end
        end
    end

    // ==========================================================
    // APB answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            if (setup) begin
                prdata <= pwrite ? 32'h0 : rd_mux;
            end
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence drive_low_s;
        !rst_pin_oe_n [*4];
    endsequence

    sequence settle_s;
        rst_pin_oe_n [*4];
    endsequence

    drive_four_a: assert property ($fell(rst_pin_oe_n) |-> drive_low_s ##1 rst_pin_oe_n)
        else $error("reset pin not driven exactly four cycles");
    sample_time_a: assert property ($rose(rst_pin_oe_n) |-> settle_s ##1 state == RSW_ST_SAMPLE)
        else $error("pin not sampled after settle");
    vec_load_a: assert property ($fell(core_hold) |-> ##3 pc_load)
        else $error("vector not loaded within three cycles");
    vec_addr_a: assert property (fetch.req && !$past(fetch.req)
        |-> fetch.addr == vec_base(cause, special))
        else $error("wrong vector address");
    ext_class_a: assert property (state == RSW_ST_SAMPLE && !pin_s |=> cause == RSW_CAUSE_EXT)
        else $error("external reset misclassified");
    int_class_a: assert property (state == RSW_ST_SAMPLE && pin_s |=> $stable(cause))
        else $error("internal cause lost");
    wdog_reset_a: assert property (wdog_to |=> state == RSW_ST_DRIVE ##0 cause == RSW_CAUSE_WDOG)
        else $error("watchdog timeout without reset");
    svc_clear_a: assert property (svc_clear |=> wdog_cnt == 22'h0)
        else $error("service pair did not clear counter");
    inhibit_gate_a: assert property (running && inhibit |=> wdog_cnt == 22'h0)
        else $error("watchdog ran while inhibited");
    cfg_once_a: assert property (wr_en && sel_cfg && config_locked && !special && running
        |=> $stable(config_reg))
        else $error("config written twice in normal mode");

endmodule : rsw_ctl

/* File: verilog/rsw_defs.svh */
`ifndef RSW_DEFS_SVH
`define RSW_DEFS_SVH

// Register byte offsets
`define RSW_OFF_CONFIG 12'h000
`define RSW_OFF_OPTION 12'h004
`define RSW_OFF_SERVICE 12'h008
`define RSW_OFF_TEST 12'h00c
`define RSW_OFF_STATUS 12'h010

// Field positions
`define RSW_CFG_WDOG_DISABLE 2
`define RSW_OPT_RATE_LO 0
`define RSW_OPT_CMON_EN 3
`define RSW_TEST_INHIBIT 0

// Reset values
`define RSW_OPTION_RESET 8'h00

// Service key values
`define RSW_KEY_ARM 8'h55
`define RSW_KEY_CLEAR 8'haa

// Restart vector addresses
`define RSW_VEC_NORM_POR 16'hfffe
`define RSW_VEC_NORM_CMON 16'hfffc
`define RSW_VEC_NORM_WDOG 16'hfffa
`define RSW_VEC_SPEC_POR 16'hbffe
`define RSW_VEC_SPEC_CMON 16'hbffc
`define RSW_VEC_SPEC_WDOG 16'hbffa

// Timing counts in E-clock cycles; the watchdog base is given as log2 of its cycle count
`define RSW_POR_WAIT_CYC 12'd4064
`define RSW_DRIVE_CYC 12'd4
`define RSW_SETTLE_CYC 12'd2
`define RSW_SYNC_LAG 12'd2
`define RSW_OPT_WINDOW 12'd64
`define RSW_WDOG_BASE_LOG2 15

`endif

/* File: verilog/rsw_pkg.sv */
package rsw_pkg;

    typedef enum logic [3:0] {
        RSW_ST_POR_WAIT = 4'b0000,
        RSW_ST_HOLD = 4'b0001,
        RSW_ST_DRIVE = 4'b0010,
        RSW_ST_SETTLE = 4'b0011,
        RSW_ST_SAMPLE = 4'b0100,
        RSW_ST_FETCH_HI = 4'b0101,
        RSW_ST_FETCH_LO = 4'b0110,
        RSW_ST_LOAD = 4'b0111,
        RSW_ST_RUN = 4'b1000
    } rsw_state_type;

    typedef enum logic [1:0] {
        RSW_CAUSE_POR = 2'b00,
        RSW_CAUSE_EXT = 2'b01,
        RSW_CAUSE_WDOG = 2'b10,
        RSW_CAUSE_CMON = 2'b11
    } rsw_cause_type;

    typedef struct packed {
        logic req;
        logic [15:0] addr;
    } rsw_fetch_type;

endpackage : rsw_pkg

/* File: verification/rsw_pin_model.sv */
`timescale 1ns/100ps

// ==========================================
// External reset circuit: pull-up and switch
module rsw_pin_model (
    input wire logic hold_low,
    input wire logic rst_pin_out,
    input wire logic rst_pin_oe_n,
    output logic rst_pin
);
    // Sharp pull-up, no RC rise delay
    assign rst_pin = (rst_pin_oe_n ? 1'b1 : rst_pin_out) & ~hold_low;
endmodule : rsw_pin_model

/* File: verification/rsw_tb.sv */
`timescale 1ns/100ps
`include "rsw_defs.svh"

module testbench;
    import rsw_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rst_pin;
    logic rst_pin_out;
    logic rst_pin_oe_n;
    logic special_mode_pin = 1'b0;
    logic clk_fail = 1'b0;
    logic pin_hold = 1'b1;
    logic core_hold;
    rsw_fetch_type fetch;
    logic [7:0] fetch_data;
    logic pc_load;
    logic [15:0] pc_value;
    logic [31:0] rd;
    logic err;
    int fail_count = 0;
    int n_checks = 0;
    int waited;

    // ==========================================
    // Clock, memory and instances
    always #12.5 pclk = ~pclk;

    // Vector memory: hi byte from address high half, lo byte from address low half
    always_ff @(posedge pclk) begin
        fetch_data <= fetch.addr[0] ? fetch.addr[7:0] : fetch.addr[15:8];
    end

    rsw_pin_model pin_model (.hold_low(pin_hold), .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n),
        .rst_pin(rst_pin));

    rsw_ctl #(.WDOG_BASE_LOG2(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rst_pin_in(rst_pin), .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n),
        .special_mode_pin(special_mode_pin), .clk_fail(clk_fail), .core_hold(core_hold), .fetch(fetch),
        .fetch_data(fetch_data), .pc_load(pc_load), .pc_value(pc_value));

    // ==========================================
    // Reporting
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    task automatic abort_wait(input string name);
        fail_count++;
        $display("mismatch %s expected done seen timeout", name);
        complete_run();
    endtask : abort_wait

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // ==========================================
    // APB master
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) abort_wait("pready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic quiet(input int cyc, input string name);
        int bad;
        bad = 0;
        repeat (cyc) begin
            @(posedge pclk);
            if (rst_pin_oe_n !== 1'b1) bad++;
        end
        check(name, 32'(bad), 32'd0);
    endtask : quiet

    // Follows one reset sequence through to the restart load
    task automatic restart(input logic [15:0] base);
        int i;
        int n;
        for (i = 0; i < 400; i++) begin
            @(posedge pclk);
            if (rst_pin_oe_n === 1'b0) break;
        end
        if (i == 400) abort_wait("pin_drive");
        waited = i;
        check("hold_in_reset", {31'd0, core_hold}, 32'd1);
        n = 0;
        while (rst_pin_oe_n === 1'b0 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        check("drive_cycles", 32'(n), 32'd4);
        for (i = 0; i < 200; i++) begin
            @(posedge pclk);
            if (fetch.req === 1'b1) break;
        end
        if (i == 200) abort_wait("fetch");
        check("vector_addr", {16'd0, fetch.addr}, {16'd0, base});
        check("core_released", {31'd0, core_hold}, 32'd0);
        n = 0;
        while (pc_load !== 1'b1 && n < 5) begin
            @(posedge pclk);
            n++;
        end
        check("fetch_to_load", 32'(n), 32'd3);
        check("restart_pc", {16'd0, pc_value}, {16'd0, base[15:8], base[7:0] | 8'h01});
    endtask : restart

    // ==========================================
    // Scenarios
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        quiet(4100, "por_wait");
        check("pin_low_hold", {31'd0, core_hold}, 32'd1);
        pin_hold <= 1'b0;
        restart(16'hfffe);
        $display("test power_on done");
        apb(1'b1, `RSW_OFF_OPTION, 32'h00000001);
        apb(1'b1, `RSW_OFF_SERVICE, 32'h00000055);
        apb(1'b1, `RSW_OFF_SERVICE, 32'h000000aa);
        apb(1'b0, `RSW_OFF_CONFIG, 32'h0);
        check("syscfg_reset", rd, 32'h00000000);
        apb(1'b0, 12'h020, 32'h0);
        check("unmapped_err", {31'd0, err}, 32'd1);
        repeat (4) begin
            quiet(30, "serviced");
            apb(1'b1, `RSW_OFF_SERVICE, 32'h00000055);
            apb(1'b1, `RSW_OFF_SERVICE, 32'h000000aa);
        end
        // Reversed key order must not clear the count; a stray value disarms
        repeat (3) begin
            apb(1'b1, `RSW_OFF_SERVICE, 32'h000000aa);
            apb(1'b1, `RSW_OFF_SERVICE, 32'h00000055);
            apb(1'b1, `RSW_OFF_SERVICE, 32'h00000000);
        end
        restart(16'hfffa);
        check("timeout_band", {31'd0, (waited + 28 >= 62) && (waited + 28 <= 68)}, 32'd1);
        $display("test watchdog done");
        apb(1'b1, `RSW_OFF_CONFIG, 32'h00000004);
        apb(1'b1, `RSW_OFF_CONFIG, 32'h00000000);
        apb(1'b0, `RSW_OFF_CONFIG, 32'h0);
        check("syscfg_once", rd, 32'h00000004);
        apb(1'b0, `RSW_OFF_TEST, 32'h0);
        check("inhibit_normal", rd, 32'h00000000);
        quiet(200, "wdog_disabled");
        $display("test disable done");
        apb(1'b1, `RSW_OFF_OPTION, 32'h00000008);
        clk_fail <= 1'b1;
        restart(16'hfffc);
        clk_fail <= 1'b0;
        apb(1'b0, `RSW_OFF_STATUS, 32'h0);
        check("status_cause", rd, {24'h0, 2'b00, RSW_CAUSE_CMON, RSW_ST_RUN});
        $display("test clock_monitor done");
        special_mode_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        pin_hold <= 1'b1;
        fork
            restart(16'hbffe);
            begin
                repeat (20) @(posedge pclk);
                pin_hold <= 1'b0;
            end
        join
        $display("test external_pin done");
        apb(1'b0, `RSW_OFF_TEST, 32'h0);
        check("inhibit_special", rd, 32'h00000001);
        apb(1'b1, `RSW_OFF_CONFIG, 32'h00000000);
        apb(1'b1, `RSW_OFF_CONFIG, 32'h00000004);
        apb(1'b1, `RSW_OFF_CONFIG, 32'h00000000);
        apb(1'b0, `RSW_OFF_CONFIG, 32'h0);
        check("syscfg_special", rd, 32'h00000000);
        quiet(100, "wdog_inhibited");
        apb(1'b1, `RSW_OFF_TEST, 32'h00000000);
        restart(16'hbffa);
        $display("test special_mode done");
        complete_run();
    end
endmodule : testbench
